// ===== dv/iefl_checker.sv
`timescale 1ns/1ns
module iefl_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [10:0] avmAddress,
    input wire logic avmRead,
    input wire logic avmWrite,
    input wire logic [31:0] avmWriteData,
    input wire logic [3:0] avmByteEnable,
    input wire logic [31:0] avmReadData,
    input wire logic avmWaitRequest,
    input wire logic timerZeroOvf,
    input wire logic timerOneOvf,
    input wire logic timerTwoMatch,
    input wire logic captureCompareEvt,
    input wire logic serialPortEvt,
    input wire logic adcDoneEvt,
    input wire logic externalEdgePin,
    input wire logic [7:0] portBInput,
    input wire logic coreIrq,
    input wire logic irq
);
    // ------------------------------
    // Port relations
    // ------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic req = avmRead | avmWrite;
    wire logic done = req & ~avmWaitRequest;
    wire logic wrOk = done & avmWrite & avmByteEnable[0];
    // Bank bits 8:7 are dropped so all four control aliases count
    wire logic ctlWr = wrOk & (avmAddress[8:2] == 7'h0B);
    property p_firstWait; $rose(req) |-> avmWaitRequest; endproperty
    a_firstWait: assert property (p_firstWait) else $error("no wait cycle");
    property p_oneWait; req & avmWaitRequest |=> !avmWaitRequest; endproperty
    a_oneWait: assert property (p_oneWait) else $error("wait too long");
    property p_rsvZero;
        done & avmRead & (avmAddress[10:2] == 9'h08C) |-> (avmReadData & 32'hFFFFFFB0) == 32'h0;
    endproperty
    a_rsvZero: assert property (p_rsvZero) else $error("enable spare bits set");
    property p_upper; done & avmRead |-> avmReadData[31:8] == 24'h000000; endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    property p_gieOff; ctlWr & !avmWriteData[7] |-> ##2 !coreIrq; endproperty
    a_gieOff: assert property (p_gieOff) else $error("request with global off");
    property p_groupOff; ctlWr & (avmWriteData[6:3] == 4'h0) |-> ##2 !coreIrq; endproperty
    a_groupOff: assert property (p_groupOff) else $error("request with groups off");
    property p_holdRd; !(avmRead & avmWaitRequest) |=> $stable(avmReadData); endproperty
    a_holdRd: assert property (p_holdRd) else $error("read data moved");
    property p_maskOff;
        wrOk & (avmAddress[10:2] == 9'h023) & (avmWriteData[7:0] == 8'h00) |-> ##2 !irq;
    endproperty
    a_maskOff: assert property (p_maskOff) else $error("irq with mask clear");
    c_core: cover property ($rose(coreIrq));
    c_irq: cover property ($rose(irq));
    c_ctl: cover property (ctlWr);
endmodule

bind iefl_top iefl_checker chk (.*);

// ===== dv/iefl_core_model.sv
`timescale 1ns/1ns
module iefl_core_model #(
    parameter int LAT = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic coreIrq,
    output logic [7:0] takenCnt
);
    // Core vectors only once the level has stood LAT+1 cycles, as a busy pipeline would
    logic [3:0] holdCnt;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            holdCnt <= 4'h0;
            takenCnt <= 8'h00;
        end else if (!coreIrq) begin
            holdCnt <= 4'h0;
        end else if (holdCnt == 4'(LAT)) begin
            holdCnt <= holdCnt + 4'h1;
            takenCnt <= takenCnt + 8'h01;
        end else if (holdCnt < 4'(LAT)) begin
            holdCnt <= holdCnt + 4'h1;
        end
    end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [10:0] avmAddress = 11'h000;
    logic avmRead = 1'h0;
    logic avmWrite = 1'h0;
    logic [31:0] avmWriteData = 32'h0;
    logic [3:0] avmByteEnable = 4'h0;
    logic [5:0] evt = 6'h00;
    logic extPin = 1'h0;
    logic [7:0] port_b_input = 8'h00;
    wire [31:0] avmReadData;
    wire avmWaitRequest;
    wire coreIrq;
    wire irq;
    wire [7:0] takenCnt;
    int failures = 0;
    int testsRun = 0;
    logic [7:0] rv;
    iefl_top dut (
        .core_clk(core_clk), .rst(rst), .avmAddress(avmAddress), .avmRead(avmRead),
        .avmWrite(avmWrite), .avmWriteData(avmWriteData), .avmByteEnable(avmByteEnable),
        .avmReadData(avmReadData), .avmWaitRequest(avmWaitRequest),
        .timerZeroOvf(evt[0]), .timerOneOvf(evt[1]), .timerTwoMatch(evt[2]),
        .captureCompareEvt(evt[3]), .serialPortEvt(evt[4]), .adcDoneEvt(evt[5]),
        .externalEdgePin(extPin), .portBInput(port_b_input), .coreIrq(coreIrq), .irq(irq)
    );
    iefl_core_model #(.LAT(3)) core (
        .core_clk(core_clk), .rst(rst), .coreIrq(coreIrq), .takenCnt(takenCnt)
    );
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [7:0] pflagOf(input logic [5:0] v);
        return {1'h0, v[5], 2'h0, v[4:1]};
    endfunction
    function automatic logic expReq(input logic [3:0] c);
        return c[3] & (c[0] | (c[2] & c[1]));
    endfunction
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [8:0] idx, input logic [7:0] wd, input logic be);
        int n;
        @(posedge core_clk);
        avmAddress <= {idx, 2'($urandom)};
        avmWriteData <= {24'($urandom), wd};
        avmByteEnable <= {3'($urandom), be};
        avmRead <= !w;
        avmWrite <= w;
        n = 0;
        // Wait state and read data are taken at the rising edge itself
        do begin
            @(posedge core_clk);
            n++;
        end while (avmWaitRequest !== 1'h0 && n < 40);
        if (avmWaitRequest !== 1'h0) begin
            failures++;
            complete_run;
        end
        rv = avmReadData[7:0];
        avmRead <= 1'h0;
        avmWrite <= 1'h0;
    endtask
    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        bus(1'h1, idx, d, 1'h1);
    endtask
    task automatic rdc(input string what, input logic [8:0] idx, input logic [7:0] exp);
        bus(1'h0, idx, 8'h00, 1'h1);
        chk(what, exp, rv);
    endtask
    // Settle on the falling edge so registered outputs are read clear of the launch edge
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge core_clk);
        evt <= v;
        @(posedge core_clk);
        evt <= 6'h00;
        cyc(2);
    endtask
    task automatic pin(input logic v);
        @(posedge core_clk);
        extPin <= v;
        cyc(3);
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        int i;
        logic [5:0] v;
        logic [7:0] d;
        void'($urandom(32'h4747F96F));
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        rdc("ctrl rst", 9'h00B, 8'h00);
        rdc("pena rst", 9'h08C, 8'h00);
        rdc("cfg rst", 9'h020, 8'h01);
        for (i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr({i[1:0], 7'h0B}, d);
            rdc("ctrl alias", {i[1:0] + 2'h1, 7'h0B}, d);
            bus(1'h1, 9'h00B, ~d, 1'h0);
            rdc("ctrl rw", 9'h18B, d);
        end
        wr(9'h08C, 8'hFF);
        rdc("pena bits", 9'h08C, 8'h4F);
        wr(9'h00C, 8'hFF);
        rdc("pflag bits", 9'h00C, 8'h4F);
        wr(9'h1FF, 8'hA5);
        rdc("unmapped", 9'h1FF, 8'h00);
        wr(9'h00C, 8'h00);
        wr(9'h08C, 8'h00);
        wr(9'h00B, 8'h00);
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 6'h3F : 6'($urandom);
            pulse(v);
            rdc("pflag", 9'h00C, pflagOf(v));
            rdc("t0 flag", 9'h00B, {5'h00, v[0], 2'h0});
            rdc("status", 9'h022, {v, 2'h0});
            rdc("status clr", 9'h022, 8'h00);
            chk("req gated", 8'h00, {7'h00, coreIrq});
            wr(9'h00C, 8'h00);
            wr(9'h00B, 8'h00);
        end
        pulse(6'h02);
        for (i = 0; i < 16; i++) begin
            wr(9'h08C, {7'h00, i[1]});
            wr(9'h00B, {i[3:2], i[0], 2'h0, i[0], 2'h0});
            cyc(3);
            chk("core req", {7'h00, expReq(i[3:0])}, {7'h00, coreIrq});
        end
        chk("core took", 8'h01, {7'h00, takenCnt != 8'h00});
        wr(9'h00B, 8'h00);
        wr(9'h00C, 8'h00);
        for (i = 0; i < 2; i++) begin
            wr(9'h020, {7'h00, i[0]});
            wr(9'h00B, 8'h00);
            pin(1'h1);
            rdc("rise", 9'h00B, {6'h00, i[0], 1'h0});
            wr(9'h00B, 8'h00);
            pin(1'h0);
            rdc("fall", 9'h00B, {6'h00, !i[0], 1'h0});
        end
        rdc("stat drain", 9'h022, 8'h09);
        @(posedge core_clk);
        port_b_input <= 8'h35;
        cyc(3);
        wr(9'h00B, 8'h00);
        rdc("chg held", 9'h00B, 8'h01);
        rdc("port", 9'h021, 8'h35);
        wr(9'h00B, 8'h00);
        rdc("chg clr", 9'h00B, 8'h00);
        rdc("stat port", 9'h022, 8'h02);
        wr(9'h023, 8'h04);
        pulse(6'h02);
        chk("irq masked", 8'h00, {7'h00, irq});
        pulse(6'h01);
        chk("irq set", 8'h01, {7'h00, irq});
        rdc("stat both", 9'h022, 8'h0C);
        cyc(2);
        chk("irq clr", 8'h00, {7'h00, irq});
        wr(9'h023, 8'h00);
        complete_run;
    end
endmodule

// ===== logic/iefl_edge_det.v
`timescale 1ns/1ns

module iefl_edge_det (
    input wire core_clk,
    input wire rst,
    input wire pinLevel,
    input wire risingSel,
    output wire edgeSeen
);

    reg prevFf;
    reg armedFf;

    // ------------------------------------------------------------------
    // Previous level; edges count only once a real sample stands in it,
    // so a pin already high or low at release is never taken for an edge
    // ------------------------------------------------------------------
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prevFf <= 1'b0;
            armedFf <= 1'b0;
        end else begin
            prevFf <= pinLevel;
            armedFf <= 1'b1;
        end
    end

    assign edgeSeen = armedFf & (risingSel ? (pinLevel & ~prevFf) : (~pinLevel & prevFf));

endmodule

// ===== logic/iefl_map.vh
`ifndef IEFL_MAP_VH
`define IEFL_MAP_VH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define IEFL_ADDR_W 11
`define IEFL_IDX_W 9
`define IEFL_IDX_LSB 2
`define IEFL_IDX_MSB 10

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IEFL_IDX_CTRL_B0 9'h00B
`define IEFL_IDX_CTRL_B1 9'h08B
`define IEFL_IDX_CTRL_B2 9'h10B
`define IEFL_IDX_CTRL_B3 9'h18B
`define IEFL_IDX_PFLAG 9'h00C
`define IEFL_IDX_PENA 9'h08C
`define IEFL_IDX_CFG 9'h020
`define IEFL_IDX_PORT 9'h021
`define IEFL_IDX_STAT 9'h022
`define IEFL_IDX_MASK 9'h023

// ----------------------------------------------------------------------
// interrupt_control fields
// ----------------------------------------------------------------------
`define IEFL_CTL_GIE 7
`define IEFL_CTL_PERIPHERAL_GROUP_ENABLE 6
`define IEFL_CTL_T0IE 5
`define IEFL_CTL_EXIE 4
`define IEFL_CTL_PCIE 3
`define IEFL_CTL_T0IF 2
`define IEFL_CTL_EXIF 1
`define IEFL_CTL_PCIF 0
`define IEFL_CTL_RST 8'h00

// ----------------------------------------------------------------------
// Peripheral enable / flag fields (same positions in both)
// ----------------------------------------------------------------------
`define IEFL_PER_ADC 6
`define IEFL_PER_SSP 3
`define IEFL_PER_CCP 2
`define IEFL_PER_T2 1
`define IEFL_PER_T1 0
`define IEFL_PER_MASK 8'h4F
`define IEFL_PER_RST 8'h00

// ----------------------------------------------------------------------
// Configuration, port and event status fields
// ----------------------------------------------------------------------
`define IEFL_CFG_EDGE 0
`define IEFL_CFG_RST 1'b1
`define IEFL_PORT_CHG_LSB 4
`define IEFL_PORT_CHG_MSB 7
`define IEFL_PORT_RST 8'h00
`define IEFL_EV_EXT 0
`define IEFL_EV_PCHG 1
`define IEFL_EV_T0 2
`define IEFL_EV_T1 3
`define IEFL_EV_T2 4
`define IEFL_EV_CCP 5
`define IEFL_EV_SSP 6
`define IEFL_EV_ADC 7
`define IEFL_EV_N 8
`define IEFL_STAT_RST 8'h00
`define IEFL_MASK_RST 8'h00

`endif

// ===== logic/iefl_top.v
`timescale 1ns/1ns
`include "iefl_map.vh"

module iefl_top (
    input wire core_clk,
    input wire rst,
    input wire [10:0] avmAddress,
    input wire avmRead,
    input wire avmWrite,
    input wire [31:0] avmWriteData,
    input wire [3:0] avmByteEnable,
    output wire [31:0] avmReadData,
    output wire avmWaitRequest,
    input wire timerZeroOvf,
    input wire timerOneOvf,
    input wire timerTwoMatch,
    input wire captureCompareEvt,
    input wire serialPortEvt,
    input wire adcDoneEvt,
    input wire externalEdgePin,
    input wire [7:0] portBInput,
    output wire coreIrq,
    output wire irq
);

    // ------------------------------------------------------------------
    // Register decode helpers
    // ------------------------------------------------------------------
    function isCtrl;
        input [8:0] idx;
        begin
            isCtrl = (idx == `IEFL_IDX_CTRL_B0) || (idx == `IEFL_IDX_CTRL_B1) ||
                     (idx == `IEFL_IDX_CTRL_B2) || (idx == `IEFL_IDX_CTRL_B3);
        end
    endfunction

    function isMapped;
        input [8:0] idx;
        begin
            isMapped = isCtrl(idx) || (idx == `IEFL_IDX_PFLAG) ||
                       (idx == `IEFL_IDX_PENA) || (idx == `IEFL_IDX_CFG) ||
                       (idx == `IEFL_IDX_PORT) || (idx == `IEFL_IDX_STAT) ||
                       (idx == `IEFL_IDX_MASK);
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg ackFf;
    reg [31:0] readDataFf;
    reg [7:0] ctrlFf;
    reg [7:0] nxt_ctrl;
    reg [7:0] perFlagFf;
    reg [7:0] nxt_perFlag;
    reg [7:0] perEnaFf;
    reg edgeSelFf;
    reg [7:0] portLatchFf;
    reg [7:0] statFf;
    reg [7:0] maskFf;
    reg coreIrqFf;
    reg irqFf;
    reg mismatchPrevFf;
    reg [7:0] rdMux;
    reg nxt_coreIrq;
    wire [8:0] regIdx;
    wire busReq;
    wire accept;
    wire wrLane;
    wire [7:0] wrByte;
    wire wrCtrl;
    wire wrPerFlag;
    wire wrPerEna;
    wire wrCfg;
    wire wrMask;
    wire rdPort;
    wire rdStat;
    wire extEdge;
    wire portMismatch;
    wire [7:0] perSet;
    wire [7:0] events;
    wire [7:0] perPending;

    // ------------------------------------------------------------------
    // Avalon slave: one wait cycle, answer at the second edge
    // ------------------------------------------------------------------
    assign regIdx = avmAddress[`IEFL_IDX_MSB:`IEFL_IDX_LSB];
    assign busReq = avmRead | avmWrite;
    assign avmWaitRequest = busReq & ~ackFf;
    assign accept = busReq & ackFf;
    assign avmReadData = readDataFf;
    assign wrLane = avmWrite & accept & avmByteEnable[0];
    assign wrByte = avmWriteData[7:0];
    assign wrCtrl = wrLane & isCtrl(regIdx);
    assign wrPerFlag = wrLane & (regIdx == `IEFL_IDX_PFLAG);
    assign wrPerEna = wrLane & (regIdx == `IEFL_IDX_PENA);
    assign wrCfg = wrLane & (regIdx == `IEFL_IDX_CFG);
    assign wrMask = wrLane & (regIdx == `IEFL_IDX_MASK);
    assign rdPort = avmRead & accept & (regIdx == `IEFL_IDX_PORT);
    assign rdStat = avmRead & accept & (regIdx == `IEFL_IDX_STAT);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ackFf <= 1'b0;
        end else begin
            ackFf <= busReq & ~ackFf;
        end
    end

    always @* begin
        rdMux = 8'h00;
        if (isCtrl(regIdx)) begin
            rdMux = ctrlFf;
        end else if (regIdx == `IEFL_IDX_PFLAG) begin
            rdMux = perFlagFf;
        end else if (regIdx == `IEFL_IDX_PENA) begin
            rdMux = perEnaFf & `IEFL_PER_MASK;
        end else if (regIdx == `IEFL_IDX_CFG) begin
            rdMux[`IEFL_CFG_EDGE] = edgeSelFf;
        end else if (regIdx == `IEFL_IDX_PORT) begin
            rdMux = portBInput;
        end else if (regIdx == `IEFL_IDX_STAT) begin
            rdMux = statFf;
        end else if (regIdx == `IEFL_IDX_MASK) begin
            rdMux = maskFf;
        end
    end

    // Data captured in the wait cycle; unmapped indices read as zero
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            readDataFf <= 32'h00000000;
        end else if (avmRead & ~ackFf) begin
            readDataFf <= isMapped(regIdx) ? {24'h000000, rdMux} : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // Source conditions
    // ------------------------------------------------------------------
    iefl_edge_det uEdge (
        .core_clk(core_clk),
        .rst(rst),
        .pinLevel(externalEdgePin),
        .risingSel(edgeSelFf),
        .edgeSeen(extEdge)
    );

    // The latch follows the port only on a read, so the mismatch lasts
    // until software has looked at the port; it takes the value the read
    // returned, so a change in the accept cycle after the wait cycle is not lost
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            portLatchFf <= `IEFL_PORT_RST;
        end else if (rdPort) begin
            portLatchFf <= readDataFf[7:0];
        end
    end

    assign portMismatch = |(portBInput[`IEFL_PORT_CHG_MSB:`IEFL_PORT_CHG_LSB] ^
                            portLatchFf[`IEFL_PORT_CHG_MSB:`IEFL_PORT_CHG_LSB]);

    assign perSet = {1'b0, adcDoneEvt, 2'b00, serialPortEvt, captureCompareEvt,
                     timerTwoMatch, timerOneOvf};

    // ------------------------------------------------------------------
    // Control register: one physical copy behind all four indices
    // ------------------------------------------------------------------
    always @* begin
        nxt_ctrl = ctrlFf;
        if (wrCtrl) begin
            nxt_ctrl = wrByte;
        end
        // Sets are applied after the write so an event never loses to a clear
        if (timerZeroOvf) begin
            nxt_ctrl[`IEFL_CTL_T0IF] = 1'b1;
        end
        if (extEdge) begin
            nxt_ctrl[`IEFL_CTL_EXIF] = 1'b1;
        end
        if (portMismatch) begin
            nxt_ctrl[`IEFL_CTL_PCIF] = 1'b1;
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlFf <= `IEFL_CTL_RST;
        end else begin
            ctrlFf <= nxt_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // Peripheral flag, enable, configuration and mask registers
    // ------------------------------------------------------------------
    always @* begin
        nxt_perFlag = perFlagFf;
        if (wrPerFlag) begin
            nxt_perFlag = wrByte & `IEFL_PER_MASK;
        end
        nxt_perFlag = nxt_perFlag | perSet;
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            perFlagFf <= `IEFL_PER_RST;
            perEnaFf <= `IEFL_PER_RST;
            edgeSelFf <= `IEFL_CFG_RST;
            maskFf <= `IEFL_MASK_RST;
        end else begin
            perFlagFf <= nxt_perFlag;
            if (wrPerEna) begin
                perEnaFf <= wrByte & `IEFL_PER_MASK;
            end
            if (wrCfg) begin
                edgeSelFf <= wrByte[`IEFL_CFG_EDGE];
            end
            if (wrMask) begin
                maskFf <= wrByte;
            end
        end
    end

    // ------------------------------------------------------------------
    // Core request
    // ------------------------------------------------------------------
    // Each bit, timer-1 at bit 0 included, passes only with its enable
    assign perPending = perFlagFf & perEnaFf;

    always @* begin
        nxt_coreIrq = ctrlFf[`IEFL_CTL_GIE] & (
            (ctrlFf[`IEFL_CTL_T0IE] & ctrlFf[`IEFL_CTL_T0IF]) |
            (ctrlFf[`IEFL_CTL_EXIE] & ctrlFf[`IEFL_CTL_EXIF]) |
            (ctrlFf[`IEFL_CTL_PCIE] & ctrlFf[`IEFL_CTL_PCIF]) |
            (ctrlFf[`IEFL_CTL_PERIPHERAL_GROUP_ENABLE] & (|perPending)));
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            coreIrqFf <= 1'b0;
        end else begin
            coreIrqFf <= nxt_coreIrq;
        end
    end

    assign coreIrq = coreIrqFf;

    // ------------------------------------------------------------------
    // Event status: sticky, cleared by reading, set beats clear
    // ------------------------------------------------------------------
    // Only bits the read returned are cleared, so an event that lands in
    // the wait cycle is still reported by the next read
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mismatchPrevFf <= 1'b0;
        end else begin
            mismatchPrevFf <= portMismatch;
        end
    end

    assign events = {adcDoneEvt, serialPortEvt, captureCompareEvt, timerTwoMatch,
                     timerOneOvf, timerZeroOvf, portMismatch & ~mismatchPrevFf, extEdge};

    genvar gi;
    generate
        for (gi = 0; gi < `IEFL_EV_N; gi = gi + 1) begin : gStat
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    statFf[gi] <= 1'b0;
                end else if (events[gi]) begin
                    statFf[gi] <= 1'b1;
                end else if (rdStat & readDataFf[gi]) begin
                    statFf[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irqFf <= 1'b0;
        end else begin
            irqFf <= |(statFf & maskFf);
        end
    end

    assign irq = irqFf;

endmodule
